// ### verilog/eas_pkg.sv
package eas_pkg;
   // register offsets on the parallel port
   localparam logic [7:0] ADDR_RX_ALARM_STATUS    = 8'h06;
   localparam logic [7:0] ADDR_FRAME_EVENT_STATUS = 8'h07;
   localparam logic [7:0] ADDR_RX_ALARM_IRQ_MASK  = 8'h16;
   localparam logic [7:0] ADDR_FRAME_EVENT_MASK   = 8'h17;
   localparam logic [7:0] MASK_RESET              = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED          = 8'h00;
   // rx_alarm_status bit positions
   localparam int unsigned BIT_SIG_ONES   = 7;
   localparam int unsigned BIT_DIST_MF    = 6;
   localparam int unsigned BIT_SIG_ZEROS  = 5;
   localparam int unsigned BIT_RX_SLIP    = 4;
   localparam int unsigned BIT_UNFR_ONES  = 3;
   localparam int unsigned BIT_REMOTE     = 2;
   localparam int unsigned BIT_CARRIER    = 1;
   localparam int unsigned BIT_SYNC_LOST  = 0;
   // frame_event_status bit positions
   localparam int unsigned BIT_RX_CAS_MF  = 7;
   localparam int unsigned BIT_RX_ALIGN   = 6;
   localparam int unsigned BIT_TX_MF      = 5;
   localparam int unsigned BIT_TIMER      = 4;
   localparam int unsigned BIT_TX_ALIGN   = 3;
   localparam int unsigned BIT_TX_CLK     = 2;
   localparam int unsigned BIT_RX_CRC4_MF = 1;
   localparam int unsigned BIT_TX_SLIP    = 0;
   // alarm criteria
   localparam int unsigned SIG_MIN_ZEROS  = 3;
   localparam int unsigned UNFR_SPAN_BITS = 512;
   localparam int unsigned UNFR_MIN_ZEROS = 3;
   localparam int unsigned REMOTE_RUN     = 3;
   localparam int unsigned CL_ZEROS_SHORT = 255;
   localparam int unsigned CL_ZEROS_LONG  = 2048;
   localparam int unsigned CL_WINDOW_BITS = 255;
   localparam int unsigned CL_MIN_ONES    = 32;
   // timing
   localparam int unsigned LINE_RATE_KHZ   = 2048;
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned CHANNEL_TIME_NS = 3906;
   localparam int unsigned TX_CLOCK_LOST_CYCLES     = CHANNEL_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned TIMER_SLOW_MS   = 1000;
   localparam int unsigned TIMER_FAST_US   = 62500;
   localparam int unsigned TIMER_SLOW_BITS = LINE_RATE_KHZ * TIMER_SLOW_MS;
   localparam int unsigned TIMER_FAST_BITS = LINE_RATE_KHZ * TIMER_FAST_US / 1000;
endpackage

// ### verilog/eas_alarm_status.sv
`timescale 1ns/100ps
// Contract
// - ts16 under three zeros per mf sets ones
// - signaling change sets both signaling flags
// - signaling and distant mf alarms work in ccs
// - ts16 all zero per mf sets zeros
// - distant mf alarm: two mf hysteresis
// - rx elastic store slip sets rx slip
// - unframed ones: under three zeros per 512
// - remote alarm: three consecutive equal bits
// - carrier loss after 255 or 2048 zeros
// - carrier back: 32 ones in 255 bits
// - sync lost flag follows framer sync
// - rx cas mf boundary sets event
// - rx align frame start sets event
// - tx mf boundary sets event
// - timer event each second or 62.5ms
// - tx align frame start sets event
// - tx clock lost; pin when enabled
// - rx crc4 mf boundary sets event
// - tx elastic store slip sets tx slip
// - rx alarm mask: 1 enables, 0 masks
// - frame event mask: 1 enables, 0 masks
module eas_alarm_status #(
   parameter int unsigned P_TIMER_SLOW_BITS = eas_pkg::TIMER_SLOW_BITS,
   parameter int unsigned P_TIMER_FAST_BITS = eas_pkg::TIMER_FAST_BITS
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // register port
   input  wire logic [7:0] i_addr,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   // configuration
   input  wire logic       i_long_zero_count_select,
   input  wire logic       i_fast_timer_select,
   input  wire logic       i_clock_loss_pin_enable,
   // line pins
   input  wire logic       i_line_rx_tip,
   input  wire logic       i_line_rx_ring,
   input  wire logic       i_tx_line_clock,
   // framer receive side
   input  wire logic       i_rx_bit_stb,
   input  wire logic       i_rx_data,
   input  wire logic       i_rx_ts16_bit,
   input  wire logic       i_rx_mf_end,
   input  wire logic       i_rx_dist_mf_stb,
   input  wire logic       i_rx_nonalign_stb,
   input  wire logic       i_rx_sig_change,
   input  wire logic       i_rx_synced,
   input  wire logic       i_rx_align_start,
   input  wire logic       i_rx_crc4_mf_end,
   input  wire logic       i_rx_slip,
   // framer transmit side
   input  wire logic       i_tx_mf_end,
   input  wire logic       i_tx_align_start,
   input  wire logic       i_tx_slip,
   // outputs
   output logic            o_irq,
   output logic            o_tx_clock_lost
);
   localparam int unsigned TW = $clog2(P_TIMER_SLOW_BITS);
   localparam int unsigned LW = $clog2(eas_pkg::TX_CLOCK_LOST_CYCLES + 1);

   logic [1:0]    ts16_zeros_q;
   logic          ts16_one_q;
   logic          sig_ones_q;
   logic          sig_zeros_q;
   logic          dist_prev_q;
   logic          dist_mf_q;
   logic [8:0]    unfr_cnt_q;
   logic [1:0]    unfr_zeros_q;
   logic          unfr_ones_q;
   logic [1:0]    ra_ones_q;
   logic [1:0]    ra_zeros_q;
   logic          remote_q;
   logic [3:0]    line_sync_q;
   logic [11:0]   cl_zero_run_q;
   logic [7:0]    cl_win_q;
   logic [5:0]    cl_ones_q;
   logic          carrier_lost_q;
   logic          sync_lost_q;
   logic          rx_slip_q;
   logic [TW-1:0] timer_q;
   logic          timer_tick_q;
   logic [2:0]    tx_line_clock_sync_q;
   logic [LW-1:0] tx_clock_lost_cnt_q;
   logic          tx_clk_lost_q;
   logic [7:0]    evt_q;
   logic [7:0]    rx_mask_q;
   logic [7:0]    evt_mask_q;
   logic [7:0]    rx_alarm;
   logic [7:0]    frame_evt;
   logic          line_one;
   logic [11:0]   cl_limit;
   logic [TW-1:0] timer_last;
   logic          rd_alarm;
   logic          rd_evt;

   assign line_one   = line_sync_q[3] | line_sync_q[2];
   assign cl_limit   = i_long_zero_count_select ? 12'(eas_pkg::CL_ZEROS_LONG)
                                                : 12'(eas_pkg::CL_ZEROS_SHORT);
   assign timer_last = i_fast_timer_select ? TW'(P_TIMER_FAST_BITS - 1)
                                           : TW'(P_TIMER_SLOW_BITS - 1);
   assign rd_alarm   = i_rd && (i_addr == eas_pkg::ADDR_RX_ALARM_STATUS);
   assign rd_evt     = i_rd && (i_addr == eas_pkg::ADDR_FRAME_EVENT_STATUS);

   assign rx_alarm = {sig_ones_q, dist_mf_q, sig_zeros_q, rx_slip_q,
                      unfr_ones_q, remote_q, carrier_lost_q, sync_lost_q};
   always_comb begin
      frame_evt = evt_q;
      frame_evt[eas_pkg::BIT_TX_CLK] = tx_clk_lost_q;
   end

   // signaling all ones / all zeros over each multiframe, no ccs gating
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ts16_zeros_q <= 2'h0;
         ts16_one_q   <= 1'b0;
         sig_ones_q   <= 1'b0;
         sig_zeros_q  <= 1'b0;
      end else if (i_rx_mf_end) begin
         sig_ones_q   <= (ts16_zeros_q < 2'(eas_pkg::SIG_MIN_ZEROS))
                         || i_rx_sig_change;
         sig_zeros_q  <= !ts16_one_q || i_rx_sig_change;
         ts16_zeros_q <= 2'h0;
         ts16_one_q   <= 1'b0;
      end else begin
         if (i_rx_sig_change) begin
            sig_ones_q  <= 1'b1;
            sig_zeros_q <= 1'b1;
         end
         if (i_rx_bit_stb && i_rx_ts16_bit) begin
            if (i_rx_data) begin
               ts16_one_q <= 1'b1;
            end else if (ts16_zeros_q != 2'h3) begin
               ts16_zeros_q <= ts16_zeros_q + 2'h1;
            end
         end
      end
   end

   // distant multiframe alarm
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dist_prev_q <= 1'b0;
         dist_mf_q   <= 1'b0;
      end else if (i_rx_dist_mf_stb) begin
         dist_prev_q <= i_rx_data;
         if (i_rx_data && dist_prev_q) begin
            dist_mf_q <= 1'b1;
         end else if (!i_rx_data && !dist_prev_q) begin
            dist_mf_q <= 1'b0;
         end
      end
   end

   // unframed all ones over 512-bit spans
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         unfr_cnt_q   <= 9'h000;
         unfr_zeros_q <= 2'h0;
         unfr_ones_q  <= 1'b0;
      end else if (i_rx_bit_stb) begin
         unfr_cnt_q <= unfr_cnt_q + 9'h001;
         if (unfr_cnt_q == 9'(eas_pkg::UNFR_SPAN_BITS - 1)) begin
            unfr_ones_q  <= ({1'b0, unfr_zeros_q} + 3'(!i_rx_data))
                            < 3'(eas_pkg::UNFR_MIN_ZEROS);
            unfr_zeros_q <= 2'h0;
         end else if (!i_rx_data && unfr_zeros_q != 2'h3) begin
            unfr_zeros_q <= unfr_zeros_q + 2'h1;
         end
      end
   end

   // remote alarm from non-align frame bit 3
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ra_ones_q  <= 2'h0;
         ra_zeros_q <= 2'h0;
         remote_q   <= 1'b0;
      end else if (i_rx_nonalign_stb) begin
         if (i_rx_data) begin
            ra_zeros_q <= 2'h0;
            ra_ones_q  <= (ra_ones_q == 2'h3) ? 2'h3 : ra_ones_q + 2'h1;
            if (ra_ones_q == 2'(eas_pkg::REMOTE_RUN - 1)) begin
               remote_q <= 1'b1;
            end
         end else begin
            ra_ones_q  <= 2'h0;
            ra_zeros_q <= (ra_zeros_q == 2'h3) ? 2'h3 : ra_zeros_q + 2'h1;
            if (ra_zeros_q == 2'(eas_pkg::REMOTE_RUN - 1)) begin
               remote_q <= 1'b0;
            end
         end
      end
   end

   // line pin synchroniser
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         line_sync_q <= 4'h0;
      end else begin
         line_sync_q <= {line_sync_q[1:0], i_line_rx_ring, i_line_rx_tip};
      end
   end

   // carrier loss and recovery
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cl_zero_run_q  <= 12'h000;
         cl_win_q       <= 8'h00;
         cl_ones_q      <= 6'h00;
         carrier_lost_q <= 1'b0;
      end else if (i_rx_bit_stb) begin
         if (line_one) begin
            cl_zero_run_q <= 12'h000;
         end else if (cl_zero_run_q != cl_limit) begin
            cl_zero_run_q <= cl_zero_run_q + 12'h001;
         end
         if (!carrier_lost_q) begin
            cl_win_q  <= 8'h00;
            cl_ones_q <= 6'h00;
            if (!line_one && cl_zero_run_q == cl_limit - 12'h001) begin
               carrier_lost_q <= 1'b1;
            end
         end else if (line_one &&
                      cl_ones_q == 6'(eas_pkg::CL_MIN_ONES - 1)) begin
            carrier_lost_q <= 1'b0;
         end else if (cl_win_q == 8'(eas_pkg::CL_WINDOW_BITS - 1)) begin
            cl_win_q  <= 8'h00;
            cl_ones_q <= 6'h00;
         end else begin
            cl_win_q  <= cl_win_q + 8'h01;
            cl_ones_q <= cl_ones_q + 6'(line_one);
         end
      end
   end

   // sync state and receive slip
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_lost_q <= 1'b0;
         rx_slip_q   <= 1'b0;
      end else begin
         sync_lost_q <= !i_rx_synced;
         if (i_rx_slip) begin
            rx_slip_q <= 1'b1;
         end else if (rd_alarm) begin
            rx_slip_q <= 1'b0;
         end
      end
   end

   // timer from receive bit clock
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_q      <= '0;
         timer_tick_q <= 1'b0;
      end else begin
         timer_tick_q <= i_rx_bit_stb && timer_q >= timer_last;
         if (i_rx_bit_stb) begin
            timer_q <= (timer_q >= timer_last) ? '0 : timer_q + TW'(1);
         end
      end
   end

   // transmit clock watchdog
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_line_clock_sync_q     <= 3'h0;
         tx_clock_lost_cnt_q      <= '0;
         tx_clk_lost_q   <= 1'b0;
         o_tx_clock_lost <= 1'b0;
      end else begin
         tx_line_clock_sync_q <= {tx_line_clock_sync_q[1:0], i_tx_line_clock};
         if (tx_line_clock_sync_q[2] != tx_line_clock_sync_q[1]) begin
            tx_clock_lost_cnt_q <= '0;
         end else if (tx_clock_lost_cnt_q != LW'(eas_pkg::TX_CLOCK_LOST_CYCLES)) begin
            tx_clock_lost_cnt_q <= tx_clock_lost_cnt_q + LW'(1);
         end
         tx_clk_lost_q   <= tx_clock_lost_cnt_q == LW'(eas_pkg::TX_CLOCK_LOST_CYCLES);
         o_tx_clock_lost <= tx_clk_lost_q && i_clock_loss_pin_enable;
      end
   end

   // sticky frame events, cleared by read, set wins
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         evt_q <= 8'h00;
      end else begin
         evt_q <= (rd_evt ? 8'h00 : evt_q) | {
            i_rx_mf_end,
            i_rx_align_start,
            i_tx_mf_end,
            timer_tick_q,
            i_tx_align_start,
            1'b0,
            i_rx_crc4_mf_end,
            i_tx_slip};
      end
   end

   // mask registers and read port
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_mask_q  <= eas_pkg::MASK_RESET;
         evt_mask_q <= eas_pkg::MASK_RESET;
         o_rdata    <= eas_pkg::RDATA_UNMAPPED;
      end else begin
         if (i_wr && i_addr == eas_pkg::ADDR_RX_ALARM_IRQ_MASK) begin
            rx_mask_q <= i_wdata;
         end
         if (i_wr && i_addr == eas_pkg::ADDR_FRAME_EVENT_MASK) begin
            evt_mask_q <= i_wdata;
         end
         if (i_rd) begin
            unique case (i_addr)
               eas_pkg::ADDR_RX_ALARM_STATUS:    o_rdata <= rx_alarm;
               eas_pkg::ADDR_FRAME_EVENT_STATUS: o_rdata <= frame_evt;
               eas_pkg::ADDR_RX_ALARM_IRQ_MASK:  o_rdata <= rx_mask_q;
               eas_pkg::ADDR_FRAME_EVENT_MASK:   o_rdata <= evt_mask_q;
               default:                          o_rdata <= eas_pkg::RDATA_UNMAPPED;
            endcase
         end
      end
   end

   // interrupt request
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(rx_alarm & rx_mask_q) || |(frame_evt & evt_mask_q);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_sig_change;
      i_rx_sig_change && !i_rx_mf_end;
   endsequence
   sequence s_naf_third_one;
      i_rx_nonalign_stb && i_rx_data && ra_ones_q == 2'h2;
   endsequence
   sequence s_tx_line_clock_still;
      tx_line_clock_sync_q[2] == tx_line_clock_sync_q[1] && tx_clock_lost_cnt_q == LW'(eas_pkg::TX_CLOCK_LOST_CYCLES - 1);
   endsequence

   property p_sig_change;
      s_sig_change |=> sig_ones_q && sig_zeros_q;
   endproperty
   a_sig_change: assert property (p_sig_change) else $error("signaling change lost");

   property p_sig_zeros;
      i_rx_mf_end && !ts16_one_q |=> sig_zeros_q;
   endproperty
   a_sig_zeros: assert property (p_sig_zeros) else $error("all zeros not flagged");

   property p_dist_mf;
      i_rx_dist_mf_stb && i_rx_data && dist_prev_q |=> dist_mf_q ##0 rx_alarm[6];
   endproperty
   a_dist_mf: assert property (p_dist_mf) else $error("distant mf alarm missed");

   property p_remote;
      s_naf_third_one |=> remote_q;
   endproperty
   a_remote: assert property (p_remote) else $error("remote alarm missed");

   property p_sync_lost;
      !i_rx_synced [*2] |=> rx_alarm[0] && $past(sync_lost_q);
   endproperty
   a_sync_lost: assert property (p_sync_lost) else $error("sync loss not shown");

   property p_rx_slip;
      i_rx_slip |=> rx_slip_q;
   endproperty
   a_rx_slip: assert property (p_rx_slip) else $error("rx slip lost");

   property p_evt_set_wins;
      rd_evt && i_rx_mf_end |=> evt_q[7];
   endproperty
   a_evt_set_wins: assert property (p_evt_set_wins) else $error("mf event lost");

   property p_tx_clk_lost;
      s_tx_line_clock_still ##1 (tx_line_clock_sync_q[2] == tx_line_clock_sync_q[1]) |=> tx_clk_lost_q;
   endproperty
   a_tx_clk_lost: assert property (p_tx_clk_lost) else $error("tx clock loss missed");

   property p_pin;
      tx_clk_lost_q && i_clock_loss_pin_enable |=> o_tx_clock_lost;
   endproperty
   a_pin: assert property (p_pin) else $error("clock loss pin low");

   property p_irq;
      (|(rx_alarm & rx_mask_q) || |(frame_evt & evt_mask_q)) |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");

   property p_irq_masked;
      !(|(rx_alarm & rx_mask_q)) && !(|(frame_evt & evt_mask_q)) |=> !o_irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked irq seen");
endmodule

// ### tb/eas_line_model.sv
`timescale 1ns/100ps
module eas_line_model #(
   parameter int HALF_NS = 244
) (
   // control from the bench
   input  wire logic i_run,
   input  wire logic i_mark,
   // line side
   output logic      o_tip,
   output logic      o_ring,
   output logic      o_tx_line_clock
);
   logic pol_q;

   initial begin
      o_tx_line_clock = 1'b0;
      pol_q  = 1'b0;
   end

   // transmit line clock, stands still while i_run is low
   always begin
      #(HALF_NS);
      if (i_run) begin
         o_tx_line_clock = ~o_tx_line_clock;
      end
   end

   // marks alternate between the two pins, a space drives neither
   always @(posedge o_tx_line_clock) begin
      pol_q <= ~pol_q;
   end

   always_comb begin
      o_tip  = i_mark & pol_q;
      o_ring = i_mark & ~pol_q;
   end
endmodule

// ### tb/eas_alarm_status_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module eas_alarm_status_tb_top;
   logic        i_clk;
   logic        i_rst_n;
   logic [7:0]  i_addr;
   logic        i_wr;
   logic        i_rd;
   logic [7:0]  i_wdata;
   logic [7:0]  o_rdata;
   logic        lz_sel;
   logic        fast_sel;
   logic        pin_en;
   logic        tip;
   logic        ring;
   logic        tx_line_clock;
   logic        run;
   logic        mark;
   logic        rx_data;
   logic        ts16;
   logic        synced;
   logic [10:0] stb;
   logic        o_irq;
   logic        o_tx_clock_lost;
   int          err_count;
   int          total_checks;
   int          cyc_count;
   int          ev_k[7] = '{0, 1, 2, 3, 4, 5, 6};
   logic [7:0]  ev_a[7] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h06};
   logic [7:0]  ev_m[7] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02, 8'h01, 8'h10};

   eas_line_model line (.i_run(run), .i_mark(mark), .o_tip(tip), .o_ring(ring), .o_tx_line_clock(tx_line_clock));

   eas_alarm_status #(.P_TIMER_SLOW_BITS(100), .P_TIMER_FAST_BITS(20)) dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .i_long_zero_count_select(lz_sel),
      .i_fast_timer_select(fast_sel), .i_clock_loss_pin_enable(pin_en),
      .i_line_rx_tip(tip), .i_line_rx_ring(ring), .i_tx_line_clock(tx_line_clock),
      .i_rx_bit_stb(stb[8]), .i_rx_data(rx_data), .i_rx_ts16_bit(ts16),
      .i_rx_mf_end(stb[0]), .i_rx_dist_mf_stb(stb[9]), .i_rx_nonalign_stb(stb[10]),
      .i_rx_sig_change(stb[7]), .i_rx_synced(synced), .i_rx_align_start(stb[1]),
      .i_rx_crc4_mf_end(stb[4]), .i_rx_slip(stb[6]), .i_tx_mf_end(stb[2]),
      .i_tx_align_start(stb[3]), .i_tx_slip(stb[5]), .o_irq(o_irq),
      .o_tx_clock_lost(o_tx_clock_lost));

   always #4 i_clk = ~i_clk;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cyc_count++;
      if (cyc_count == 30000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                         input string nm);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      `CHK(nm, e, o_rdata & m)
   endtask

   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(posedge i_clk);
         stb[k] <= 1'b1;
         @(posedge i_clk);
         stb[k] <= 1'b0;
      end
   endtask

   task automatic bits(input int n);
      @(posedge i_clk);
      stb[8] <= 1'b1;
      repeat (n) @(posedge i_clk);
      stb[8] <= 1'b0;
   endtask

   task automatic irq_chk(input logic e);
      repeat (2) @(posedge i_clk);
      #1;
      `CHK("irq", e, o_irq)
   endtask

   initial begin
      i_clk = 0; i_rst_n = 0; i_addr = 0; i_wr = 0; i_rd = 0; i_wdata = 0;
      lz_sel = 0; fast_sel = 0; pin_en = 0; run = 1; mark = 1; rx_data = 0;
      ts16 = 0; synced = 1; stb = 0; err_count = 0; total_checks = 0; cyc_count = 0;
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // reset values, mask access, read-only and unmapped places
      rd_chk(8'h16, 8'hFF, 8'h00, "alarm mask reset");
      rd_chk(8'h17, 8'hFF, 8'h00, "event mask reset");
      wr(8'h16, 8'hA5);
      wr(8'h17, 8'h5A);
      wr(8'h06, 8'hFF);
      wr(8'h20, 8'hFF);
      rd_chk(8'h16, 8'hFF, 8'hA5, "alarm mask rw");
      rd_chk(8'h17, 8'hFF, 8'h5A, "event mask rw");
      rd_chk(8'h06, 8'h10, 8'h00, "status read only");
      rd_chk(8'h20, 8'hFF, 8'h00, "unmapped read");
      wr(8'h16, 8'h00);
      wr(8'h17, 8'h00);
      rd_chk(8'h07, 8'hFB, 8'h00, "events idle");
      // each event strobe sets its sticky bit, a read clears it
      for (int i = 0; i < 7; i++) begin
         pulse(ev_k[i], 1);
         rd_chk(ev_a[i], ev_m[i], ev_m[i], "event set");
         rd_chk(ev_a[i], ev_m[i], 8'h00, "event cleared");
      end
      // an event in the cycle of the clearing read survives it
      @(posedge i_clk);
      i_addr <= 8'h07;
      i_rd   <= 1'b1;
      stb[0] <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      stb[0] <= 1'b0;
      rd_chk(8'h07, 8'h80, 8'h80, "set wins over clear");
      // interrupt request against masks
      pulse(5, 1);
      irq_chk(1'b0);
      wr(8'h17, 8'h01);
      irq_chk(1'b1);
      rd_chk(8'h07, 8'h01, 8'h01, "tx slip pending");
      irq_chk(1'b0);
      wr(8'h17, 8'h00);
      wr(8'h16, 8'h10);
      pulse(6, 1);
      irq_chk(1'b1);
      rd_chk(8'h06, 8'h10, 8'h10, "rx slip pending");
      irq_chk(1'b0);
      wr(8'h16, 8'h00);
      // sync lost follows the framer
      synced <= 1'b0;
      rd_chk(8'h06, 8'h01, 8'h01, "sync lost");
      synced <= 1'b1;
      rd_chk(8'h06, 8'h01, 8'h00, "sync back");
      // remote alarm and distant multiframe alarm hysteresis
      rx_data <= 1'b1;
      pulse(10, 2);
      rd_chk(8'h06, 8'h04, 8'h00, "remote two ones");
      pulse(10, 1);
      rd_chk(8'h06, 8'h04, 8'h04, "remote three ones");
      pulse(9, 1);
      rd_chk(8'h06, 8'h40, 8'h00, "distant mf one");
      pulse(9, 1);
      rd_chk(8'h06, 8'h40, 8'h40, "distant mf two");
      rx_data <= 1'b0;
      pulse(10, 2);
      pulse(9, 1);
      rd_chk(8'h06, 8'h44, 8'h44, "alarms held");
      pulse(10, 1);
      pulse(9, 1);
      rd_chk(8'h06, 8'h44, 8'h00, "alarms dropped");
      // signaling flags judged per multiframe of timeslot 16 bits
      ts16 <= 1'b1;
      bits(16);
      pulse(0, 1);
      rd_chk(8'h06, 8'hA0, 8'h20, "sig all zeros");
      rx_data <= 1'b1;
      bits(14);
      rx_data <= 1'b0;
      bits(2);
      pulse(0, 1);
      rd_chk(8'h06, 8'hA0, 8'h80, "sig all ones");
      bits(3);
      pulse(0, 1);
      rd_chk(8'h06, 8'hA0, 8'h20, "sig three zeros");
      pulse(7, 1);
      rd_chk(8'h06, 8'hA0, 8'hA0, "sig change");
      ts16 <= 1'b0;
      // unframed all ones: 1024 strobes hold at least one whole span
      rx_data <= 1'b1;
      bits(1024);
      rd_chk(8'h06, 8'h08, 8'h08, "unframed ones");
      rx_data <= 1'b0;
      bits(1024);
      rd_chk(8'h06, 8'h08, 8'h00, "unframed ones gone");
      // carrier loss short and long counts, recovery by 32 ones
      for (int l = 0; l < 2; l++) begin
         lz_sel <= l[0];
         mark   <= 1'b0;
         repeat (4) @(posedge i_clk);
         bits(l ? 2047 : 254);
         rd_chk(8'h06, 8'h02, 8'h00, "zeros below count");
         bits(1);
         rd_chk(8'h06, 8'h02, 8'h02, "carrier lost");
         mark <= 1'b1;
         repeat (4) @(posedge i_clk);
         bits(31);
         rd_chk(8'h06, 8'h02, 8'h02, "31 ones");
         bits(1);
         rd_chk(8'h06, 8'h02, 8'h00, "carrier back");
      end
      // timer ticks in bit strobes, slow then fast
      rd_chk(8'h07, 8'h04, 8'h00, "clear events");
      bits(100);
      rd_chk(8'h07, 8'h10, 8'h10, "slow timer");
      fast_sel <= 1'b1;
      rd_chk(8'h07, 8'h04, 8'h00, "clear events");
      bits(20);
      rd_chk(8'h07, 8'h10, 8'h10, "fast timer");
      // transmit clock stops, flag after one channel time
      pin_en <= 1'b1;
      run    <= 1'b0;
      repeat (400) @(posedge i_clk);
      rd_chk(8'h07, 8'h04, 8'h00, "tx clock still ok");
      repeat (100) @(posedge i_clk);
      rd_chk(8'h07, 8'h04, 8'h04, "tx clock lost");
      `CHK("clock loss pin", 1'b1, o_tx_clock_lost)
      pin_en <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      `CHK("clock loss pin off", 1'b0, o_tx_clock_lost)
      run <= 1'b1;
      repeat (100) @(posedge i_clk);
      rd_chk(8'h07, 8'h04, 8'h00, "tx clock back");
      complete_run();
   end
endmodule
